// ---- wgic_bank.v ----
// Write guard and interrupt output configuration registers.
// Assumes up_wr/up_rd are one-cycle strobes from logic on the same clock,
// and irq_pending is a level from logic on that clock as well, so neither
// passes a synchroniser.
`timescale 1ns/1ns
`default_nettype none
`include "wgic_map.vh"
module wgic_bank #(
	parameter DATA_W = 8,
	parameter ADDR_W = 8
) (
	input  wire              clock,
	input  wire              sys_rst,
	input  wire [ADDR_W-1:0] up_addr,
	input  wire              up_wr,
	input  wire              up_rd,
	input  wire [DATA_W-1:0] up_wdata,
	output reg  [DATA_W-1:0] up_rdata,
	output wire              ext_wr,
	output wire              guard_open,
	input  wire              irq_pending,
	output reg               irq_pin_out,
	output reg               irq_pin_oe
);

	// Pin drive modes, decoded from the live config bits
	localparam [1:0] PIN_ALWAYS = 2'b00;
	localparam [1:0] PIN_ACTIVE = 2'b01;
	localparam [1:0] PIN_GPO    = 2'b10;

	localparam [DATA_W-1:0] CFG_RST  = `WGIC_IRQ_CFG_RST;
	localparam [DATA_W-1:0] CFG_MASK = `WGIC_IRQ_CFG_MASK;

	wire [DATA_W-1:0] irq_cfg_q;
	reg  [DATA_W-1:0] guard_q;
	reg  [DATA_W-1:0] guard_d;
	reg  [DATA_W-1:0] rdata_d;
	reg               pin_out_d;
	reg               pin_oe_d;
	reg  [1:0]        pin_mode;
	wire              hit_cfg;
	wire              hit_guard;
	wire              hit_none;
	wire              other_wr;
	wire              cfg_wr;
	wire              single_shot;
	wire              pol;
	wire              tri_en;
	wire              irq_pin_as_general_output;

	// Address match, shared by the write and the read decode
	function addr_is;
		input [ADDR_W-1:0] addr;
		input [ADDR_W-1:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	function key_opens;
		input [DATA_W-1:0] key;
		begin
			key_opens = (key == `WGIC_GUARD_OPEN) ||
			            (key == `WGIC_GUARD_SINGLE);
		end
	endfunction

	function key_is_single;
		input [DATA_W-1:0] key;
		begin
			key_is_single = (key == `WGIC_GUARD_SINGLE);
		end
	endfunction

	// Asserted pin level for a pending request, its inverse otherwise
	function pin_level;
		input pending;
		input polarity;
		begin
			pin_level = pending ? polarity : ~polarity;
		end
	endfunction

	assign hit_cfg     = addr_is(up_addr, `WGIC_ADDR_IRQ_CFG);
	assign hit_guard   = addr_is(up_addr, `WGIC_ADDR_GUARD);
	assign hit_none    = !hit_cfg && !hit_guard;

	// Guard register itself stays writable, otherwise it could never unlock
	assign guard_open  = key_opens(guard_q);
	assign single_shot = key_is_single(guard_q);

	// Every write outside the guard register passes the same gate,
	// including writes to the interrupt config register
	assign other_wr    = up_wr && !hit_guard && guard_open;
	assign cfg_wr      = other_wr && hit_cfg;
	assign ext_wr      = other_wr && !hit_cfg;

	always @* begin
		guard_d = guard_q;
		if (up_wr && hit_guard) begin
			guard_d = up_wdata;
		end else if (other_wr && single_shot) begin
			// Writing the guard itself does not use up the single write
			guard_d = `WGIC_GUARD_RELOCK;
		end
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			guard_q <= `WGIC_GUARD_RST;
		end else begin
			guard_q <= guard_d;
		end
	end

	// Interrupt config register: one flip-flop per live bit, the rest
	// are tied low so they read back as zero
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_cfg_bit
			if (CFG_MASK[gi]) begin : g_live
				reg bit_q;
				always @(posedge clock or posedge sys_rst) begin
					if (sys_rst) begin
						bit_q <= CFG_RST[gi];
					end else if (cfg_wr) begin
						bit_q <= up_wdata[gi];
					end
				end
				assign irq_cfg_q[gi] = bit_q;
			end else begin : g_dead
				assign irq_cfg_q[gi] = 1'b0;
			end
		end
	endgenerate

	always @* begin
		rdata_d = `WGIC_RDATA_UNMAPPED;
		if (hit_cfg) begin
			rdata_d = irq_cfg_q;
		end else if (hit_guard) begin
			rdata_d = guard_q;
		end else if (hit_none) begin
			rdata_d = `WGIC_RDATA_UNMAPPED;
		end
	end

	// Read data holds until the next read strobe
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			up_rdata <= `WGIC_RDATA_RST;
		end else if (up_rd) begin
			up_rdata <= rdata_d;
		end
	end

	assign pol    = irq_cfg_q[`WGIC_BIT_POLARITY];
	assign tri_en = irq_cfg_q[`WGIC_BIT_TRISTATE];
	assign irq_pin_as_general_output = irq_cfg_q[`WGIC_BIT_GPO];

	// General output mode overrides the tri-state choice
	always @* begin
		pin_mode = PIN_ALWAYS;
		if (irq_pin_as_general_output) begin
			pin_mode = PIN_GPO;
		end else if (tri_en) begin
			pin_mode = PIN_ACTIVE;
		end
	end

	always @* begin
		pin_out_d = ~pol;
		case (pin_mode)
			PIN_ALWAYS: begin
				pin_out_d = pin_level(irq_pending, pol);
			end
			PIN_ACTIVE: begin
				pin_out_d = pin_level(irq_pending, pol);
			end
			PIN_GPO: begin
				pin_out_d = pol;
			end
			default: begin
				pin_out_d = ~pol;
			end
		endcase
	end

	// Floating the pin while idle lets it share a wired line
	always @* begin
		pin_oe_d = 1'b1;
		case (pin_mode)
			PIN_ALWAYS: begin
				pin_oe_d = 1'b1;
			end
			PIN_ACTIVE: begin
				pin_oe_d = irq_pending;
			end
			PIN_GPO: begin
				pin_oe_d = 1'b1;
			end
			default: begin
				pin_oe_d = 1'b0;
			end
		endcase
	end

	// Pin drive registered so it never glitches on config writes
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_pin_out <= `WGIC_PIN_OUT_RST;
		end else begin
			irq_pin_out <= pin_out_d;
		end
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_pin_oe <= `WGIC_PIN_OE_RST;
		end else begin
			irq_pin_oe <= pin_oe_d;
		end
	end
endmodule // wgic_bank
`default_nettype wire

// ---- wgic_bank_properties.sv ----
// Port checker for the guard bank.
// Assumes one clock and an active-high reset.
`timescale 1ns/1ns
`default_nettype none
module wgic_props (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       up_wr,
	input wire logic       up_rd,
	input wire logic       ext_wr,
	input wire logic       guard_open,
	input wire logic       irq_pending,
	input wire logic       irq_pin_oe,
	input wire logic [7:0] up_addr,
	input wire logic [7:0] up_rdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_gate;
		ext_wr |-> up_wr && guard_open &&
			up_addr != 8'h7D && up_addr != 8'h7E;
	endproperty
	a_gate: assert property (p_gate) else $error("stray write passed");
	property p_open; guard_open && up_wr && up_addr < 8'h7D |-> ext_wr; endproperty
	a_open: assert property (p_open) else $error("open write lost");
	property p_rst; $fell(sys_rst) |-> guard_open; endproperty
	a_rst: assert property (p_rst) else $error("guard shut at reset");
	property p_shut; !guard_open && up_wr |-> !ext_wr; endproperty
	a_shut: assert property (p_shut) else $error("locked write passed");
	property p_float; !irq_pin_oe |-> !$past(irq_pending); endproperty
	a_float: assert property (p_float) else $error("pin floated");
	property p_hold; !up_rd |=> $stable(up_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	cover property (ext_wr);
	cover property (!guard_open && up_wr);
	cover property (guard_open ##1 !guard_open);
endmodule // wgic_props
bind wgic_bank wgic_props wgic_props_i (
	.clock(clock),
	.sys_rst(sys_rst),
	.up_wr(up_wr),
	.up_rd(up_rd),
	.ext_wr(ext_wr),
	.guard_open(guard_open),
	.irq_pending(irq_pending),
	.irq_pin_oe(irq_pin_oe),
	.up_addr(up_addr),
	.up_rdata(up_rdata)
);
`default_nettype wire

// ---- wgic_host.sv ----
// Host model: one strobe per access, driven at the falling edge.
// Assumes the bank samples strobes at the rising edge.
`timescale 1ns/1ns
`default_nettype none
module wgic_host (
	input  wire logic       clock,
	output var  logic [7:0] up_addr, up_wdata,
	output var  logic       up_wr, up_rd
);
	initial {up_wr, up_rd, up_addr, up_wdata} = 18'h0;
	task acc(input logic w, input logic [7:0] a, d);
		@(negedge clock) {up_wr, up_rd, up_addr, up_wdata} = {w, !w, a, d};
		@(negedge clock) {up_wr, up_rd} = 2'h0;
	endtask
endmodule // wgic_host
`default_nettype wire

// ---- wgic_map.vh ----
// Constants for the write guard and interrupt output configuration bank.
// Assumes an 8-bit register port with 8-bit addresses.
// How it works
// - Interrupt config register is read/write and resets to 0x02.
// - Bit 0 of interrupt config picks the interrupt pin's asserted level.
// - With level bit 0, a pending interrupt drives the pin low.
// - Guard register is 8-bit read/write, resets to 0x85, fully open.
// - Guard values other than 0x85 and 0x86 block writes elsewhere.
// - Guard 0x85 lets every write through until software changes it.
// - With the general output bit clear, tri-state bit drives pin only while asserted, else floats it.
`ifndef WGIC_MAP_VH
`define WGIC_MAP_VH
`define WGIC_ADDR_IRQ_CFG   8'h7D
`define WGIC_ADDR_GUARD     8'h7E
`define WGIC_IRQ_CFG_RST    8'h02
`define WGIC_IRQ_CFG_MASK   8'h07
`define WGIC_GUARD_RST      8'h85
`define WGIC_GUARD_OPEN     8'h85
`define WGIC_GUARD_SINGLE   8'h86
`define WGIC_GUARD_RELOCK   8'h00
`define WGIC_BIT_POLARITY   0
`define WGIC_BIT_TRISTATE   1
`define WGIC_BIT_GPO        2
`define WGIC_RDATA_RST      8'h00
`define WGIC_RDATA_UNMAPPED 8'h00
`define WGIC_PIN_OUT_RST    1'b1
`define WGIC_PIN_OE_RST     1'b0
`endif

// ---- write_guard_and_irq_config_bench.sv ----
// Bench: host model drives, monitor checks each read a cycle later.
// Assumes the bank, host model and checker share one clock.
`timescale 1ns/1ns
`default_nettype none
module write_guard_and_irq_config_bench;
	logic       clock = 0;
	logic       sys_rst = 1;
	logic       irq_pending = 0;
	logic       rd_q = 0;
	logic       up_wr, up_rd, po, oe, ew, go;
	logic [7:0] up_addr, up_wdata, up_rdata, r;
	logic [7:0] exp_q[$];
	int         num_errors = 0, compares = 0, seed = 18, ext_cnt = 0;
	always #10 clock = ~clock;
	wgic_host wgic_host_i (.clock, .up_addr, .up_wdata, .up_wr, .up_rd);
	wgic_bank wgic_bank_i (.clock, .sys_rst, .up_addr, .up_wr, .up_rd,
		.up_wdata, .up_rdata, .ext_wr(ew), .guard_open(go), .irq_pending,
		.irq_pin_out(po), .irq_pin_oe(oe));
	task chk(input string n, input logic [7:0] e, s);
		compares++;
		if (e !== s) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	always @(posedge clock) if (ew === 1'b1) ext_cnt++;
	task rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		wgic_host_i.acc(0, a, 8'h00);
	endtask
	always @(posedge clock) rd_q <= up_rd;
	always @(negedge clock) if (rd_q) chk("rdata", exp_q.pop_front(), up_rdata);
	task tally_and_finish;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Tests need about 60 cycles; 1000 leaves ample margin
	initial begin #20000 num_errors++; tally_and_finish; end
	initial begin
		repeat (20) @(negedge clock);
		sys_rst = 0;
		rd(8'h7E, 8'h85);
		rd(8'h7D, 8'h02);
		chk("guard_open", 8'h01, {7'h0, go});
		$display("reset test done");
		wgic_host_i.acc(1, 8'h7E, 8'h86);
		chk("guard_open", 8'h01, {7'h0, go});
		wgic_host_i.acc(1, 8'h7D, 8'h01);
		chk("guard_open", 8'h00, {7'h0, go});
		wgic_host_i.acc(1, 8'h7D, 8'h03);
		wgic_host_i.acc(1, 8'h10, 8'h5A);
		chk("ext_wr count", 8'h00, ext_cnt[7:0]);
		rd(8'h7D, 8'h01);
		rd(8'h7E, 8'h00);
		$display("single write test done");
		r = 8'($random(seed));
		wgic_host_i.acc(1, 8'h7E, 8'h85);
		wgic_host_i.acc(1, 8'h10, r);
		chk("ext_wr count", 8'h01, ext_cnt[7:0]);
		wgic_host_i.acc(1, 8'h7D, r);
		rd(8'h7D, r & 8'h07);
		rd(8'h7E, 8'h85);
		$display("open guard test done");
		wgic_host_i.acc(1, 8'h7D, 8'h00);
		irq_pending = 1;
		repeat (2) @(negedge clock);
		chk("pin low", 8'h01, {6'h0, po, oe});
		wgic_host_i.acc(1, 8'h7D, 8'h01);
		repeat (2) @(negedge clock);
		chk("pin high", 8'h03, {6'h0, po, oe});
		irq_pending = 0;
		wgic_host_i.acc(1, 8'h7D, 8'h02);
		repeat (2) @(negedge clock);
		chk("pin float", 8'h02, {6'h0, po, oe});
		wgic_host_i.acc(1, 8'h7D, 8'h05);
		repeat (2) @(negedge clock);
		chk("pin general", 8'h03, {6'h0, po, oe});
		$display("pin test done");
		tally_and_finish;
	end
endmodule // write_guard_and_irq_config_bench
`default_nettype wire
